// ==== rtl/esp_spi.sv ====
// full-duplex serial port core, master or slave, 3-wire or 4-wire
// Summary of operation
// - master drives mosi from shift register msb
// - miso floats when disabled or deselected 4-wire slave
// - 3-wire slave always drives miso
// - deselected 4-wire slave ignores sck
// - mode 00: 3-wire, slave always selected
// - mode 01: select input, falling edge stops master
// - mode 1x: select output equals low bit
// - select pin unrouted only in 3-wire mode
// - master write loads buffer, starts if shifter empty
// - master shifts out and in simultaneously, msb first
// - byte end sets transfer done flag
// - received byte moves into receive buffer
// - multi-master fault clears enables, sets fault flag
// - select mode resets to 01
// - slave counts eight edges then completes byte
// - slave never starts, preloads shifter from buffer
// - 4-wire slave active on low select, counter reset
// - 3-wire slave counter reset only by enable
// - write with full buffer ignored, collision flag
// - slave overrun keeps old byte, sets flag
// - flags stay until software clears them
// - phase picks latch edge, polarity idle level
`default_nettype none
module esp_spi
    import esp_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              sck_in,
    output logic                   sck_out,
    output logic                   sck_oe_n,
    input  wire logic              mosi_in,
    output logic                   mosi_out,
    output logic                   mosi_oe_n,
    input  wire logic              miso_in,
    output logic                   miso_out,
    output logic                   miso_oe_n,
    input  wire logic              nss_in,
    output logic                   nss_out,
    output logic                   nss_oe_n,
    output logic                   nss_routed,
    input  wire logic              ctrl_wr,
    input  wire logic              ctrl_port_enable,
    input  wire logic              ctrl_master_enable,
    input  wire logic [1:0]        ctrl_select_mode_field,
    input  wire logic              ctrl_clock_phase_select,
    input  wire logic              ctrl_clock_polarity_select,
    input  wire logic [DIV_W-1:0]  ctrl_clk_div,
    input  wire logic              serial_data_wr,
    input  wire logic [DATA_W-1:0] serial_data_wdata,
    input  wire logic              serial_data_rd,
    output logic [DATA_W-1:0]      serial_data_rdata,
    input  wire logic              clr_transfer_done,
    input  wire logic              clr_write_collision,
    input  wire logic              clr_mode_fault,
    input  wire logic              clr_receive_overrun,
    output logic                   port_enable_bit,
    output logic                   master_enable_bit,
    output logic [1:0]             select_mode_field,
    output logic                   transfer_done_flag,
    output logic                   write_collision_flag,
    output logic                   mode_fault_flag,
    output logic                   receive_overrun_flag,
    output logic                   rx_full,
    output logic                   busy
);
    esp_link_if lnk ();

    esp_mst_state_type  state_reg;
    logic               port_en_reg;
    logic               mst_en_reg;
    logic [1:0]         sel_reg;
    logic               cpha_reg;
    logic               cpol_reg;
    logic [DIV_W-1:0]   div_reg;
    logic [DIV_W-1:0]   div_cnt_reg;
    logic [3:0]         edge_reg;
    logic               sck_lvl_reg;
    logic               miso_lat_reg;
    logic [DATA_W-1:0]  sr_reg;
    logic               sr_full_reg;
    logic [DATA_W-1:0]  tx_buf_reg;
    logic               tx_full_reg;
    logic [DATA_W-1:0]  rx_buf_reg;
    logic               rx_full_reg;
    logic               done_flag_reg;
    logic               write_collision_flag_flag_reg;
    logic               mode_fault_flag_flag_reg;
    logic               ovr_flag_reg;
    logic [1:0]         pin_s1_reg;
    logic [1:0]         pin_s2_reg;
    logic [1:0]         pin_s3_reg;
    logic [1:0]         pin_f_reg;
    logic               nss_prev_reg;
    logic               dn_s1_reg;
    logic               dn_s2_reg;
    logic               dn_s3_reg;
    logic               mst_act;
    logic               slv_act;
    logic               slave_sel;
    logic               tick;
    logic               sample;
    logic               last;
    logic               slv_done;
    logic               done_any;
    logic               load_sr;
    logic               wr_ok;
    logic               mf_evt;
    logic [DATA_W-1:0]  mst_rx_byte;
    logic [DATA_W-1:0]  rx_in_byte;

    esp_slave_link u_link
    (
        .link_sck (sck_in),
        .reset_n  (reset_n),
        .lnk      (lnk)
    );

    assign mst_act   = port_en_reg & mst_en_reg;
    assign slv_act   = port_en_reg & ~mst_en_reg;
    // select mode 1x is for masters only; a slave there stays deselected
    assign slave_sel = (sel_reg == SEL_3WIRE)
                     | ((sel_reg == SEL_4W_IN) & ~nss_in);

    // raw pin in the link reset: the slave must be live well within the
    // eight-clock select setup that the external master grants
    assign lnk.link_rst_n = reset_n & slv_act
                          & ((sel_reg == SEL_3WIRE)
                          | ((sel_reg == SEL_4W_IN) & ~nss_in));
    assign lnk.tx_byte    = sr_reg;
    assign lnk.mosi       = mosi_in;
    assign lnk.phase_inv  = cpol_reg ^ cpha_reg;

    // three-stage synchronisers, a change counts when stages two and three
    // agree; bit 1 is the select pin, bit 0 is miso
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_s1_reg   <= PIN_SYNC_RST;
            pin_s2_reg   <= PIN_SYNC_RST;
            pin_s3_reg   <= PIN_SYNC_RST;
            pin_f_reg    <= PIN_SYNC_RST;
            nss_prev_reg <= PIN_SYNC_RST[PIN_NSS_POS];
        end
        else
        begin
            pin_s1_reg   <= {nss_in, miso_in};
            pin_s2_reg   <= pin_s1_reg;
            pin_s3_reg   <= pin_s2_reg;
            pin_f_reg    <= (pin_s3_reg & ~(pin_s2_reg ^ pin_s3_reg))
                          | (pin_f_reg & (pin_s2_reg ^ pin_s3_reg));
            nss_prev_reg <= pin_f_reg[PIN_NSS_POS];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dn_s1_reg <= 1'b0;
            dn_s2_reg <= 1'b0;
            dn_s3_reg <= 1'b0;
        end
        else
        begin
            dn_s1_reg <= lnk.done_tgl;
            dn_s2_reg <= dn_s1_reg;
            dn_s3_reg <= dn_s2_reg;
        end
    end

    assign slv_done = (dn_s2_reg ^ dn_s3_reg) & slv_act;
    assign mf_evt   = mst_act & (sel_reg == SEL_4W_IN) & nss_prev_reg
                    & ~pin_f_reg[PIN_NSS_POS];

    // control state; a mode fault overrides a same-cycle control write
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            port_en_reg <= PORT_EN_RST;
            mst_en_reg  <= MST_EN_RST;
            sel_reg     <= SEL_MODE_RST;
            cpha_reg    <= CPHA_RST;
            cpol_reg    <= CPOL_RST;
            div_reg     <= DIV_RST;
        end
        else if (mf_evt)
        begin
            port_en_reg <= 1'b0;
            mst_en_reg  <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            port_en_reg <= ctrl_port_enable;
            mst_en_reg  <= ctrl_master_enable;
            sel_reg     <= ctrl_select_mode_field;
            cpha_reg    <= ctrl_clock_phase_select;
            cpol_reg    <= ctrl_clock_polarity_select;
            div_reg     <= ctrl_clk_div;
        end
    end

    // half an sck period lasts div_reg + 1 clocks
    assign tick   = (state_reg == ESP_RUN) & (div_cnt_reg == div_reg);
    assign sample = (edge_reg[0] == cpha_reg);
    assign last   = tick & (edge_reg == EDGE_LAST);
    assign load_sr = tx_full_reg & ~sr_full_reg & port_en_reg;
    assign wr_ok  = serial_data_wr & ~tx_full_reg;
    // with phase 1 the final bit is sampled on the last edge, never shifted
    assign mst_rx_byte = {sr_reg[6:0], cpha_reg ? pin_f_reg[PIN_MISO_POS]
                                                : miso_lat_reg};
    assign done_any   = last | slv_done;
    assign rx_in_byte = mst_en_reg ? mst_rx_byte : lnk.rx_byte;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg   <= ESP_IDLE;
            div_cnt_reg <= DIV_RST;
            edge_reg    <= EDGE_FIRST;
            sck_lvl_reg <= CPOL_RST;
        end
        else if (!mst_act)
        begin
            state_reg   <= ESP_IDLE;
            div_cnt_reg <= DIV_RST;
            edge_reg    <= EDGE_FIRST;
            sck_lvl_reg <= cpol_reg;
        end
        else
        begin
            case (state_reg)
                ESP_IDLE:
                begin
                    sck_lvl_reg <= cpol_reg;
                    div_cnt_reg <= DIV_RST;
                    edge_reg    <= EDGE_FIRST;
                    if (load_sr)
                        state_reg <= ESP_RUN;
                end
                ESP_RUN:
                begin
                    if (tick)
                    begin
                        div_cnt_reg <= DIV_RST;
                        sck_lvl_reg <= ~sck_lvl_reg;
                        edge_reg    <= edge_reg + 4'h1;
                        if (last)
                            state_reg <= ESP_IDLE;
                    end
                    else
                        div_cnt_reg <= div_cnt_reg + 8'h01;
                end
                default:
                    state_reg <= ESP_IDLE;
            endcase
        end
    end

    // one shifter: shifts while master, holds the outgoing byte while slave
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sr_reg       <= DATA_RST;
            miso_lat_reg <= 1'b0;
        end
        else if (load_sr)
            sr_reg <= tx_buf_reg;
        else if (tick)
        begin
            if (sample)
                miso_lat_reg <= pin_f_reg[PIN_MISO_POS];
            else if (edge_reg != EDGE_FIRST)
                sr_reg <= {sr_reg[6:0], miso_lat_reg};
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            sr_full_reg <= 1'b0;
        else if (load_sr)
            sr_full_reg <= 1'b1;
        else if (done_any | ~port_en_reg)
            sr_full_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_buf_reg  <= DATA_RST;
            tx_full_reg <= 1'b0;
        end
        else if (wr_ok)
        begin
            tx_buf_reg  <= serial_data_wdata;
            tx_full_reg <= 1'b1;
        end
        else if (load_sr)
            tx_full_reg <= 1'b0;
    end

    // a master always refreshes the buffer; only a slave can overrun
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_buf_reg  <= DATA_RST;
            rx_full_reg <= 1'b0;
        end
        else if (done_any & ~(slv_done & rx_full_reg))
        begin
            rx_buf_reg  <= rx_in_byte;
            rx_full_reg <= 1'b1;
        end
        else if (serial_data_rd)
            rx_full_reg <= 1'b0;
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done_flag_reg <= 1'b0;
            write_collision_flag_flag_reg <= 1'b0;
            mode_fault_flag_flag_reg <= 1'b0;
            ovr_flag_reg  <= 1'b0;
        end
        else
        begin
            done_flag_reg <= done_any
                           | (done_flag_reg & ~clr_transfer_done);
            write_collision_flag_flag_reg <= (serial_data_wr & tx_full_reg)
                           | (write_collision_flag_flag_reg & ~clr_write_collision);
            mode_fault_flag_flag_reg <= mf_evt
                           | (mode_fault_flag_flag_reg & ~clr_mode_fault);
            ovr_flag_reg  <= (slv_done & rx_full_reg)
                           | (ovr_flag_reg & ~clr_receive_overrun);
        end
    end

    assign sck_out    = sck_lvl_reg;
    assign sck_oe_n   = ~mst_act;
    assign mosi_out   = sr_reg[DATA_W-1];
    assign mosi_oe_n  = ~mst_act;
    assign miso_out   = lnk.miso_bit;
    assign miso_oe_n  = ~(slv_act & slave_sel);
    assign nss_out    = sel_reg[SEL_LVL_POS];
    assign nss_oe_n   = ~sel_reg[SEL_OUT_POS];
    assign nss_routed = (sel_reg != SEL_3WIRE);

    assign serial_data_rdata    = rx_buf_reg;
    assign port_enable_bit      = port_en_reg;
    assign master_enable_bit    = mst_en_reg;
    assign select_mode_field    = sel_reg;
    assign transfer_done_flag   = done_flag_reg;
    assign write_collision_flag = write_collision_flag_flag_reg;
    assign mode_fault_flag      = mode_fault_flag_flag_reg;
    assign receive_overrun_flag = ovr_flag_reg;
    assign rx_full              = rx_full_reg;
    assign busy                 = (state_reg == ESP_RUN);
endmodule
`default_nettype wire

// ==== inc/esp_pkg.sv ====
// constants and types shared by the serial port core and its link logic
`default_nettype none
package esp_pkg;
    localparam int          DATA_W       = 8;
    localparam int          DIV_W        = 8;
    localparam int          SEL_OUT_POS  = 1;
    localparam int          SEL_LVL_POS  = 0;
    localparam int          PIN_NSS_POS  = 1;
    localparam int          PIN_MISO_POS = 0;
    localparam logic [1:0]  SEL_3WIRE    = 2'h0;
    localparam logic [1:0]  SEL_4W_IN    = 2'h1;
    localparam logic [1:0]  SEL_MODE_RST = 2'h1;
    localparam logic [1:0]  PIN_SYNC_RST = 2'h2;
    localparam logic        PORT_EN_RST  = 1'h0;
    localparam logic        MST_EN_RST   = 1'h0;
    localparam logic        CPHA_RST     = 1'h0;
    localparam logic        CPOL_RST     = 1'h0;
    localparam logic [7:0]  DIV_RST      = 8'h00;
    localparam logic [7:0]  DATA_RST     = 8'h00;
    localparam logic [3:0]  EDGE_FIRST   = 4'h0;
    localparam logic [3:0]  EDGE_LAST    = 4'hF;
    localparam logic [2:0]  BIT_FIRST    = 3'h0;
    localparam logic [2:0]  BIT_LAST     = 3'h7;

    typedef enum logic [0:0]
    {
        ESP_IDLE = 1'b0,
        ESP_RUN  = 1'b1
    } esp_mst_state_type;
endpackage
`default_nettype wire

// ==== inc/esp_link_if.sv ====
// signals passed between the core and the slave logic on the link clock
`default_nettype none
interface esp_link_if;
    logic [7:0] tx_byte;
    logic       phase_inv;
    logic       link_rst_n;
    logic       mosi;
    logic       miso_bit;
    logic       done_tgl;
    logic [7:0] rx_byte;

    modport core
    (
        output tx_byte,
        output phase_inv,
        output link_rst_n,
        output mosi,
        input  miso_bit,
        input  done_tgl,
        input  rx_byte
    );

    modport link
    (
        input  tx_byte,
        input  phase_inv,
        input  link_rst_n,
        input  mosi,
        output miso_bit,
        output done_tgl,
        output rx_byte
    );
endinterface
`default_nettype wire

// ==== rtl/esp_slave_link.sv ====
// slave-mode shifting logic clocked by the external serial clock
`default_nettype none
module esp_slave_link
    import esp_pkg::*;
(
    input  wire logic  link_sck,
    input  wire logic  reset_n,
    esp_link_if.link   lnk
);
    logic       sclk_eff;
    logic [2:0] cnt_reg;
    logic [2:0] out_idx_reg;
    logic [6:0] rx_sr_reg;
    logic [7:0] rx_hold_reg;
    logic       done_tgl_reg;

    // phase and polarity are quasi-static: only changed with the port off
    assign sclk_eff = link_sck ^ lnk.phase_inv;

    // held in reset while disabled or deselected, so sck is ignored then
    always_ff @(posedge sclk_eff or negedge lnk.link_rst_n)
    begin
        if (!lnk.link_rst_n)
            cnt_reg <= BIT_FIRST;
        else
            cnt_reg <= cnt_reg + 3'h1;
    end

    always_ff @(negedge sclk_eff or negedge lnk.link_rst_n)
    begin
        if (!lnk.link_rst_n)
            out_idx_reg <= BIT_FIRST;
        else
            out_idx_reg <= cnt_reg;
    end

    // toggle is not cleared by the link reset, else a false event appears
    always_ff @(posedge sclk_eff or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_sr_reg    <= 7'h00;
            rx_hold_reg  <= DATA_RST;
            done_tgl_reg <= 1'b0;
        end
        else
        begin
            rx_sr_reg <= {rx_sr_reg[5:0], lnk.mosi};
            if (cnt_reg == BIT_LAST)
            begin
                rx_hold_reg  <= {rx_sr_reg, lnk.mosi};
                done_tgl_reg <= ~done_tgl_reg;
            end
        end
    end

    assign lnk.miso_bit = lnk.tx_byte[BIT_LAST - out_idx_reg];
    assign lnk.done_tgl = done_tgl_reg;
    assign lnk.rx_byte  = rx_hold_reg;
endmodule
`default_nettype wire

// ==== verif/esp_spi_assertions.sv ====
// concurrent checks on the serial port's top-level pins
`default_nettype none
module esp_spi_assertions
    import esp_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic       nss_in,
    input wire logic       serial_data_wr,
    input wire logic       clr_transfer_done,
    input wire logic       mosi_oe_n,
    input wire logic       miso_oe_n,
    input wire logic       nss_out,
    input wire logic       nss_oe_n,
    input wire logic       nss_routed,
    input wire logic       port_enable_bit,
    input wire logic       master_enable_bit,
    input wire logic [1:0] select_mode_field,
    input wire logic       transfer_done_flag,
    input wire logic       write_collision_flag,
    input wire logic       mode_fault_flag,
    input wire logic       receive_overrun_flag,
    input wire logic       rx_full
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_mosi_drive: assert property (
        port_enable_bit && master_enable_bit |-> !mosi_oe_n)
        else $error("mosi not driven by enabled master");
    a_miso_float_off: assert property (
        !port_enable_bit |-> miso_oe_n)
        else $error("miso driven while port disabled");
    // select may pass a synchronizer, so only a settled high select counts
    a_miso_desel: assert property (
        (port_enable_bit && !master_enable_bit
         && select_mode_field == SEL_4W_IN && nss_in) [*4] |-> miso_oe_n)
        else $error("miso driven by deselected slave");
    a_miso_3wire: assert property (
        port_enable_bit && !master_enable_bit
        && select_mode_field == SEL_3WIRE |-> !miso_oe_n)
        else $error("3-wire slave not driving miso");
    a_nss_out_level: assert property (
        select_mode_field[1] |-> !nss_oe_n && nss_out == select_mode_field[0])
        else $error("select output level wrong");
    a_nss_routed: assert property (
        nss_routed == (select_mode_field != SEL_3WIRE))
        else $error("select pin routing wrong");
    a_fault_on_fall: assert property (
        $fell(nss_in) && port_enable_bit && master_enable_bit
        && select_mode_field == SEL_4W_IN |-> ##[1:8] mode_fault_flag)
        else $error("no mode fault after select fell");
    a_fault_disable: assert property (
        $rose(mode_fault_flag) |-> !port_enable_bit && !master_enable_bit)
        else $error("mode fault left port enabled");
    a_done_sticky: assert property (
        transfer_done_flag && !clr_transfer_done |=> transfer_done_flag)
        else $error("done flag cleared by hardware");
    a_done_rx_full: assert property (
        $rose(transfer_done_flag) |-> rx_full)
        else $error("done flag without received byte");
    a_write_collision_flag_twice: assert property (
        serial_data_wr ##1 serial_data_wr |=> write_collision_flag)
        else $error("second write did not collide");
    c_master_done: cover property (
        $rose(transfer_done_flag) && master_enable_bit);
    c_overrun: cover property ($rose(receive_overrun_flag));
    c_fault: cover property ($rose(mode_fault_flag));
endmodule
`default_nettype wire

// ==== verif/esp_ext_spi.sv ====
// behavioural far-side device: slave to a master core, master to a slave
`default_nettype none
module esp_ext_spi
(
    input  wire logic sck_m,
    input  wire logic mosi_m,
    input  wire logic miso_line,
    output var logic  sck,
    output var logic  mosi,
    output var logic  nss,
    output logic      miso
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ssr = 8'h00;
    logic       cap;
    initial
    begin
        sck = 1'b0;
        mosi = 1'b0;
        nss = 1'b1;
    end
    assign miso = ssr[7];
    // sample on the rising edge, shift on the falling one
    always @(posedge sck_m)
        cap = mosi_m;
    always @(negedge sck_m)
        ssr = {ssr[6:0], cap};
    task automatic load(input logic [7:0] b);
        ssr = b;
    endtask
    // sck runs even when sel leaves nss high; mosi is scrambled once released
    task automatic xfer(input logic [7:0] tx, input logic sel,
                        output logic [7:0] rx);
        #13 nss = ~sel;
        #400;
        for (int i = 7; i >= 0; i--)
        begin
            mosi = tx[i];
            #80 rx[i] = miso_line;
            sck = 1'b1;
            #80 sck = 1'b0;
        end
        #400 nss = 1'b1;
        mosi = ~mosi;
    endtask
endmodule
`default_nettype wire

// ==== verif/test_enhanced_spi_master_slave.sv ====
// self-checking bench for the serial port core
`default_nettype none
module test_enhanced_spi_master_slave
    import esp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, reset_n, ctrl_wr, ctrl_port_enable, ctrl_master_enable;
    logic ctrl_clock_phase_select, ctrl_clock_polarity_select;
    logic serial_data_wr, serial_data_rd, clr_transfer_done;
    logic clr_write_collision, clr_mode_fault, clr_receive_overrun;
    logic [1:0] ctrl_select_mode_field, select_mode_field;
    logic [7:0] ctrl_clk_div, serial_data_wdata, serial_data_rdata, rx;
    logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
    logic nss_out, nss_oe_n, nss_routed, port_enable_bit, master_enable_bit;
    logic transfer_done_flag, write_collision_flag, mode_fault_flag;
    logic receive_overrun_flag, rx_full, busy, ext_sck, ext_mosi, ext_nss;
    logic ext_miso;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    wire sck_in = sck_oe_n ? ext_sck : sck_out;
    wire mosi_in = mosi_oe_n ? ext_mosi : mosi_out;
    wire miso_in = miso_oe_n ? ext_miso : miso_out;
    wire nss_in = nss_oe_n ? ext_nss : nss_out;

    esp_spi DUT (.*);
    esp_ext_spi u_ext (.sck_m(sck_in), .mosi_m(mosi_in), .miso_line(miso_in),
        .sck(ext_sck), .mosi(ext_mosi), .nss(ext_nss), .miso(ext_miso));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ctrl(input logic pe, input logic me,
                        input logic [1:0] m, input logic [7:0] d);
        @(negedge ref_clk);
        ctrl_port_enable = pe;
        ctrl_master_enable = me;
        ctrl_select_mode_field = m;
        ctrl_clk_div = d;
        ctrl_wr = 1'b1;
        @(negedge ref_clk);
        ctrl_wr = 1'b0;
    endtask
    task automatic dwr(input logic [7:0] b);
        @(negedge ref_clk);
        serial_data_wr = 1'b1;
        serial_data_wdata = b;
        @(negedge ref_clk);
        serial_data_wr = 1'b0;
    endtask
    // reads the receive buffer and clears every flag in one pulse
    task automatic clr_all();
        @(negedge ref_clk);
        {serial_data_rd, clr_transfer_done, clr_write_collision} = 3'h7;
        {clr_mode_fault, clr_receive_overrun} = 2'h3;
        @(negedge ref_clk);
        {serial_data_rd, clr_transfer_done, clr_write_collision} = 3'h0;
        {clr_mode_fault, clr_receive_overrun} = 2'h0;
    endtask
    task automatic wait_done();
        for (int n = 0; n < 3000 && transfer_done_flag !== 1'b1; n++)
            @(negedge ref_clk);
    endtask

    initial
    begin
        {ctrl_wr, ctrl_port_enable, ctrl_master_enable} = 3'h0;
        {ctrl_clock_phase_select, ctrl_clock_polarity_select} = 2'h0;
        {serial_data_wr, serial_data_rd, clr_transfer_done} = 3'h0;
        {clr_write_collision, clr_mode_fault, clr_receive_overrun} = 3'h0;
        ctrl_select_mode_field = SEL_4W_IN;
        ctrl_clk_div = 8'h00;
        serial_data_wdata = 8'h00;
        reset_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        check(8'(select_mode_field), 8'h01);
        check(8'(miso_oe_n), 8'h01);
        u_ext.load(8'h3C);
        ctrl(1'b1, 1'b1, 2'h2, 8'h07);
        check(8'({nss_oe_n, nss_out}), 8'h00);
        dwr(8'hA5);
        @(negedge ref_clk);
        check(8'(busy), 8'h01);
        wait_done();
        check(8'({busy, rx_full}), 8'h01);
        check(serial_data_rdata, 8'h3C);
        check(u_ext.ssr, 8'hA5);
        repeat (20) @(negedge ref_clk);
        check(8'(transfer_done_flag), 8'h01);
        clr_all();
        // second write lands while the buffer still holds the first
        u_ext.load(8'h0F);
        @(negedge ref_clk);
        serial_data_wr = 1'b1;
        serial_data_wdata = 8'h11;
        @(negedge ref_clk);
        serial_data_wdata = 8'h22;
        @(negedge ref_clk);
        serial_data_wr = 1'b0;
        wait_done();
        check(8'(write_collision_flag), 8'h01);
        check(u_ext.ssr, 8'h11);
        check(serial_data_rdata, 8'h0F);
        clr_all();
        for (int m = 0; m < 4; m++)
        begin
            ctrl(1'b0, 1'b0, 2'(m), 8'h00);
            check(8'(nss_routed), 8'(m != 0));
            check(8'(nss_oe_n), 8'(m < 2));
        end
        // the select pin just pulsed low as an output: let it settle, or
        // the synchroniser hands the enabled master a stale falling edge
        repeat (8) @(negedge ref_clk);
        ctrl(1'b1, 1'b1, SEL_4W_IN, 8'h07);
        repeat (8) @(negedge ref_clk);
        check(8'({mode_fault_flag, port_enable_bit, master_enable_bit}),
              8'h03);
        u_ext.nss = 1'b0;
        repeat (8) @(negedge ref_clk);
        check(8'({mode_fault_flag, port_enable_bit, master_enable_bit}),
              8'h04);
        u_ext.nss = 1'b1;
        clr_all();
        ctrl(1'b1, 1'b0, SEL_4W_IN, 8'h00);
        check(8'(miso_oe_n), 8'h01);
        dwr(8'h96);
        u_ext.xfer(8'h5A, 1'b1, rx);
        wait_done();
        check(serial_data_rdata, 8'h5A);
        check(rx, 8'h96);
        u_ext.xfer(8'hC3, 1'b1, rx);
        repeat (10) @(negedge ref_clk);
        check(8'(receive_overrun_flag), 8'h01);
        check(serial_data_rdata, 8'h5A);
        clr_all();
        u_ext.xfer(8'hFF, 1'b0, rx);
        repeat (10) @(negedge ref_clk);
        check(8'(transfer_done_flag), 8'h00);
        u_ext.xfer(8'h69, 1'b1, rx);
        wait_done();
        check(serial_data_rdata, 8'h69);
        clr_all();
        ctrl(1'b0, 1'b0, SEL_3WIRE, 8'h00);
        ctrl(1'b1, 1'b0, SEL_3WIRE, 8'h00);
        check(8'(miso_oe_n), 8'h00);
        u_ext.xfer(8'h81, 1'b0, rx);
        wait_done();
        check(serial_data_rdata, 8'h81);
        give_verdict();
    end
endmodule

bind esp_spi esp_spi_assertions u_chk (.*);
`default_nettype wire
